// ===== logic/digipot_regs.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Overview of operation
// - sixteen nine-bit locations, few implemented
// - wipers at 00h, 01h only when dual
// - terminal control at address 04h
// - reading 05h returns 1F7h
// - supply up loads mid-scale, then operates
// - mid-scale 80h eight-bit, 40h seven-bit
// - reset loads terminal control with 1FFh
// - supply low disables and ignores bus
// - terminal write applies when command completes
// - net1 lock blocks net1 control writes
// - net0 lock blocks net0 control writes
// - bit 8 enables general call accept
// - bit 7 low forces net1 shutdown
// - bits 6..4 connect net1 a, w, b
// - bit 3 low forces net0 shutdown
// - bits 2..0 connect net0 a, w, b
// - control changes never alter wipers
// - shutdown ignores but keeps connect bits
// ---------------------------------------------------------------------
module digipot_regs
   import digipot_pkg::*;
#(
   parameter bit DUAL_NET = 1'b1,   // two resistor networks
   parameter bit RES_8BIT = 1'b1    // 8-bit ladder, else 7-bit
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // supply monitor pin, high above trip point
   input  wire logic              supply_ok,
   // write locks held by the nonvolatile side
   input  wire logic              net0_write_lock,
   input  wire logic              net1_write_lock,
   // decoded serial command port
   input  wire logic              cmd_valid,
   input  wire logic              cmd_write,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [DATA_W-1:0] cmd_wdata,
   input  wire logic              cmd_done,
   // read answer
   output logic                   rd_valid,
   output logic [DATA_W-1:0]      rd_data,
   // interface state
   output logic                   bus_enabled,
   output logic                   general_call_accept,
   // wiper positions to ladder decoders
   output logic [DATA_W-1:0]      wiper0_pos,
   output logic [DATA_W-1:0]      wiper1_pos,
   // network 0 switches
   output logic                   net0_term_a_on,
   output logic                   net0_wiper_on,
   output logic                   net0_term_b_on,
   output logic                   net0_wiper_to_b,
   // network 1 switches
   output logic                   net1_term_a_on,
   output logic                   net1_wiper_on,
   output logic                   net1_term_b_on,
   output logic                   net1_wiper_to_b
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------

   // merge a write into control, keeping locked nibbles
   function automatic logic [8:0] lock_merge(input logic [8:0] old_v,
                                             input logic [8:0] new_v,
                                             input logic       lk0,
                                             input logic       lk1);
      logic [8:0] r;
      r = new_v;
      if (lk1) begin
         r[NET1_LSB +: 4] = old_v[NET1_LSB +: 4];
      end
      if (lk0) begin
         r[NET0_LSB +: 4] = old_v[NET0_LSB +: 4];
      end
      return r;
   endfunction : lock_merge

   // wiper1 address decode for the write path and its checks
   function automatic logic is_wiper1(input logic [3:0] a);
      return (a == ADDR_WIPER1) && DUAL_NET;
   endfunction : is_wiper1

   // -----------------------------------------------------------------
   // supply synchroniser
   // -----------------------------------------------------------------
   logic sup_meta_q;        // first stage, read only by second
   logic sup_sync_q;        // safe supply level

   // the monitor is analog, so it is treated as asynchronous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sup_meta_q <= 1'b0;
         sup_sync_q <= 1'b0;
      end else begin
         sup_meta_q <= supply_ok;
         sup_sync_q <= sup_meta_q;
      end
   end

   // -----------------------------------------------------------------
   // supply sequencing
   // -----------------------------------------------------------------
   op_state_e state_d;      // next sequencing state
   op_state_e state_q;      // current sequencing state

   // off until supply good, one load cycle, then run
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (sup_sync_q) begin
               state_d = ST_LOAD;
            end
         end
         ST_LOAD: begin
            state_d = sup_sync_q ? ST_RUN : ST_OFF;
         end
         ST_RUN: begin
            if (!sup_sync_q) begin
               state_d = ST_OFF;
            end
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   logic run;               // serial interface live
   assign run = (state_q == ST_RUN);

   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   logic [8:0] mid_scale;   // reset wiper code for this ladder
   assign mid_scale = RES_8BIT ? MID_SCALE_8B : MID_SCALE_7B;

   logic       wr_hit;      // accepted write
   logic       rd_hit;      // accepted read
   assign wr_hit = run && cmd_valid && cmd_write;
   assign rd_hit = run && cmd_valid && !cmd_write;

   logic [8:0] wiper0_d, wiper0_q;   // wiper_position_0
   logic [8:0] wiper1_d, wiper1_q;   // wiper_position_1
   logic [8:0] terminal_control_d, terminal_control_q;       // terminal_control as written
   logic [8:0] applied_d, applied_q; // control seen by the networks
   logic       pend_d, pend_q;       // control write awaiting completion

   // writes and default loading; off state holds defaults so that
   // a brown-out never leaves a corrupt value behind
   always_comb begin
      wiper0_d  = wiper0_q;
      wiper1_d  = wiper1_q;
      terminal_control_d    = terminal_control_q;
      applied_d = applied_q;
      pend_d    = pend_q;
      if (!run) begin
         wiper0_d  = mid_scale;
         wiper1_d  = mid_scale;
         terminal_control_d    = TERMINAL_CONTROL_RESET;
         applied_d = TERMINAL_CONTROL_RESET;
         pend_d    = 1'b0;
      end else begin
         // unmatched addresses fall through untouched
         if (wr_hit) begin
            if (cmd_addr == ADDR_WIPER0) begin
               wiper0_d = cmd_wdata;
            end else if (is_wiper1(cmd_addr)) begin
               wiper1_d = cmd_wdata;
            end else if (cmd_addr == ADDR_TERMINAL_CONTROL) begin
               // wipers untouched by control writes
               terminal_control_d = lock_merge(terminal_control_q, cmd_wdata,
                                   net0_write_lock, net1_write_lock);
               pend_d = 1'b1;
            end else begin
               pend_d = pend_q;
            end
         end
         // apply only at end of the whole serial command
         if (cmd_done) begin
            // only a command that wrote control moves the switches
            if (pend_d) begin
               applied_d = terminal_control_d;
            end
            pend_d    = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wiper0_q  <= MID_SCALE_8B;
         wiper1_q  <= MID_SCALE_8B;
         terminal_control_q    <= TERMINAL_CONTROL_RESET;
         applied_q <= TERMINAL_CONTROL_RESET;
         pend_q    <= 1'b0;
      end else begin
         wiper0_q  <= wiper0_d;
         wiper1_q  <= wiper1_d;
         terminal_control_q    <= terminal_control_d;
         applied_q <= applied_d;
         pend_q    <= pend_d;
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   logic       rvalid_d, rvalid_q;   // one-cycle read strobe
   logic [8:0] rdata_d, rdata_q;     // read answer

   // unimplemented locations read as zero
   always_comb begin
      rvalid_d = rd_hit;
      rdata_d  = rdata_q;
      if (rd_hit) begin
         case (cmd_addr)
            ADDR_WIPER0:  rdata_d = wiper0_q;
            ADDR_WIPER1:  rdata_d = DUAL_NET ? wiper1_q : READ_ZERO;
            ADDR_TERMINAL_CONTROL:    rdata_d = terminal_control_q;
            ADDR_RSVD_ST: rdata_d = RSVD_ST_VALUE;
            default:      rdata_d = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= READ_ZERO;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign rd_valid            = rvalid_q;
   assign rd_data             = rdata_q;
   assign bus_enabled         = run;
   assign general_call_accept = applied_q[GC_ACCEPT_BIT];
   assign wiper0_pos          = wiper0_q;
   assign wiper1_pos          = DUAL_NET ? wiper1_q : READ_ZERO;

   // network 0 switch drive
   net_terminal_drive u_net0 (
      .clk        (clk),
      .rst_n      (rst_n),
      .ctrl       (applied_q[NET0_LSB +: 4]),
      .term_a_on  (net0_term_a_on),
      .wiper_on   (net0_wiper_on),
      .term_b_on  (net0_term_b_on),
      .wiper_to_b (net0_wiper_to_b)
   );

   // network 1 switch drive
   net_terminal_drive u_net1 (
      .clk        (clk),
      .rst_n      (rst_n),
      .ctrl       (applied_q[NET1_LSB +: 4]),
      .term_a_on  (net1_term_a_on),
      .wiper_on   (net1_wiper_on),
      .term_b_on  (net1_term_b_on),
      .wiper_to_b (net1_wiper_to_b)
   );

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   bus_ignored_a: assert property (!run && cmd_valid |=> !rd_valid)
      else $error("bus activity answered while supply low");

   terminal_control_default_a: assert property ((state_q == ST_LOAD) |=> terminal_control_q == TERMINAL_CONTROL_RESET)
      else $error("terminal control not loaded with default");

   wiper_mid_a: assert property ((state_q == ST_LOAD) |=> wiper0_q == mid_scale)
      else $error("wiper not loaded with mid-scale");

   rsvd_read_a: assert property (rd_hit && cmd_addr == ADDR_RSVD_ST
      |=> rd_valid && rd_data == RSVD_ST_VALUE)
      else $error("reserved slot read wrong value");

   terminal_control_defer_a: assert property (run && !cmd_done |=> $stable(applied_q))
      else $error("control applied before command completed");

   net1_lock_a: assert property (wr_hit && cmd_addr == ADDR_TERMINAL_CONTROL && net1_write_lock
      |=> terminal_control_q[7:4] == $past(terminal_control_q[7:4]))
      else $error("locked net1 control bits changed");

   net0_lock_a: assert property (wr_hit && cmd_addr == ADDR_TERMINAL_CONTROL && net0_write_lock
      |=> terminal_control_q[3:0] == $past(terminal_control_q[3:0]))
      else $error("locked net0 control bits changed");

   wiper_keep_a: assert property (wr_hit && cmd_addr == ADDR_TERMINAL_CONTROL
      |=> $stable(wiper0_q) && $stable(wiper1_q))
      else $error("control write altered a wiper");

   unmapped_wr_a: assert property (wr_hit && cmd_addr != ADDR_WIPER0
      && !is_wiper1(cmd_addr) && cmd_addr != ADDR_TERMINAL_CONTROL
      |=> $stable(wiper0_q) && $stable(wiper1_q) && $stable(terminal_control_q))
      else $error("unmapped write changed a register");

endmodule : digipot_regs

// ===== logic/net_terminal_drive.sv
`timescale 1ns/1ps

// per-network terminal switch drive, shutdown overrides stored bits
module net_terminal_drive
   import digipot_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // applied control nibble
   input  wire logic [3:0] ctrl,
   // switch controls
   output logic            term_a_on,
   output logic            wiper_on,
   output logic            term_b_on,
   output logic            wiper_to_b
);

   // -----------------------------------------------------------------
   // switch state
   // -----------------------------------------------------------------
   logic [3:0] sw_d;        // {a, w, b, w-b short} next
   logic [3:0] sw_q;        // registered switch drive

   // shutdown forces a open and w tied to b, stored bits kept upstream
   always_comb begin
      if (!ctrl[SHDN_OFS]) begin
         sw_d = 4'h7;
      end else begin
         sw_d = {ctrl[TA_OFS], ctrl[WIP_OFS], ctrl[TB_OFS], 1'b0};
      end
   end

   // register the drive so switches never glitch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_q <= 4'hE;
      end else begin
         sw_q <= sw_d;
      end
   end

   assign term_a_on  = sw_q[3];
   assign wiper_on   = sw_q[2];
   assign term_b_on  = sw_q[1];
   assign wiper_to_b = sw_q[0];

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   shutdown_force_a: assert property (@(posedge clk) disable iff (!rst_n)
      !ctrl[SHDN_OFS] |=> (!term_a_on && wiper_to_b))
      else $error("shutdown did not force network state");

   stored_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
      ctrl[SHDN_OFS] |=> (term_a_on == $past(ctrl[TA_OFS]) && !wiper_to_b))
      else $error("connect bit not driving terminal");

endmodule : net_terminal_drive

// ===== shared/digipot_pkg.sv
package digipot_pkg;

   // -----------------------------------------------------------------
   // register address space
   // -----------------------------------------------------------------
   localparam int          ADDR_W        = 4;       // sixteen locations
   localparam int          DATA_W        = 9;       // nine bits each
   localparam logic [3:0]  ADDR_WIPER0   = 4'h0;    // wiper_position_0
   localparam logic [3:0]  ADDR_WIPER1   = 4'h1;    // wiper_position_1
   localparam logic [3:0]  ADDR_TERMINAL_CONTROL     = 4'h4;    // terminal_control
   localparam logic [3:0]  ADDR_RSVD_ST  = 4'h5;    // reserved_status_slot

   // -----------------------------------------------------------------
   // reset and fixed values
   // -----------------------------------------------------------------
   localparam logic [8:0]  TERMINAL_CONTROL_RESET    = 9'h1FF;  // all terminals connected
   localparam logic [8:0]  RSVD_ST_VALUE = 9'h1F7;  // fixed read value
   localparam logic [8:0]  MID_SCALE_8B  = 9'h080;  // 8-bit resolution
   localparam logic [8:0]  MID_SCALE_7B  = 9'h040;  // 7-bit resolution
   localparam logic [8:0]  READ_ZERO     = 9'h000;  // unimplemented read

   // -----------------------------------------------------------------
   // terminal_control field positions
   // -----------------------------------------------------------------
   localparam int          GC_ACCEPT_BIT = 8;       // general_call_accept
   localparam int          NET1_LSB      = 4;       // net1 nibble low bit
   localparam int          NET0_LSB      = 0;       // net0 nibble low bit
   localparam int          SHDN_OFS      = 3;       // network_shutdown_n
   localparam int          TA_OFS        = 2;       // term a connect
   localparam int          WIP_OFS       = 1;       // wiper connect
   localparam int          TB_OFS        = 0;       // term b connect

   // -----------------------------------------------------------------
   // supply sequencing states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,     // supply below trip point
      ST_LOAD = 2'b01,     // load defaults
      ST_RUN  = 2'b10      // digital operation
   } op_state_e;

endpackage : digipot_pkg

// ===== verif/digipot_volatile_register_map_bench.sv
`timescale 1ns/1ps

module digipot_volatile_register_map_bench
   import digipot_pkg::*;
   ;

   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic              clk = 1'b0;        // 250 MHz
   logic              rst_n;             // async, active low
   logic              supply_ok;         // supply monitor level
   logic              net0_write_lock;   // lock levels
   logic              net1_write_lock;
   logic              cmd_valid, cmd_write, cmd_done;
   logic [3:0]        cmd_addr;
   logic [8:0]        cmd_wdata, rd_data, wiper0_pos, wiper1_pos;
   logic              rd_valid, bus_enabled, general_call_accept;
   logic              net0_term_a_on, net0_wiper_on, net0_term_b_on, net0_wiper_to_b;
   logic              net1_term_a_on, net1_wiper_on, net1_term_b_on, net1_wiper_to_b;
   logic [8:0]        sw_state;          // gc, net1 a/w/b/w2b, net0 a/w/b/w2b
   logic [8:0]        v;                 // read result
   logic              ok;                // read answered
   int                bad_count   = 0;
   int                checks_done = 0;

   assign sw_state = {general_call_accept,
                      net1_term_a_on, net1_wiper_on, net1_term_b_on, net1_wiper_to_b,
                      net0_term_a_on, net0_wiper_on, net0_term_b_on, net0_wiper_to_b};

   // clock, half period 2 ns
   always #2 clk = ~clk;

   // -----------------------------------------------------------------
   // host model and device
   // -----------------------------------------------------------------
   host_ctrl_model host (
      .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .rd_valid(rd_valid), .rd_data(rd_data));

   digipot_regs #(.DUAL_NET(1'b1), .RES_8BIT(1'b1)) dut (
      .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
      .net0_write_lock(net0_write_lock), .net1_write_lock(net1_write_lock),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .rd_valid(rd_valid), .rd_data(rd_data),
      .bus_enabled(bus_enabled), .general_call_accept(general_call_accept),
      .wiper0_pos(wiper0_pos), .wiper1_pos(wiper1_pos),
      .net0_term_a_on(net0_term_a_on), .net0_wiper_on(net0_wiper_on),
      .net0_term_b_on(net0_term_b_on), .net0_wiper_to_b(net0_wiper_to_b),
      .net1_term_a_on(net1_term_a_on), .net1_wiper_on(net1_wiper_on),
      .net1_term_b_on(net1_term_b_on), .net1_wiper_to_b(net1_wiper_to_b));

   // single-network seven-bit variant shares the command lines
   logic [8:0]        w7_pos0, w7_pos1;  // its wiper outputs
   digipot_regs #(.DUAL_NET(1'b0), .RES_8BIT(1'b0)) dut_single (
      .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
      .net0_write_lock(net0_write_lock), .net1_write_lock(net1_write_lock),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .rd_valid(), .rd_data(),
      .bus_enabled(), .general_call_accept(), .wiper0_pos(w7_pos0), .wiper1_pos(w7_pos1),
      .net0_term_a_on(), .net0_wiper_on(), .net0_term_b_on(), .net0_wiper_to_b(),
      .net1_term_a_on(), .net1_wiper_on(), .net1_term_b_on(), .net1_wiper_to_b());

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // case equality so an unknown never matches
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // read must be answered and carry the expected word
   task automatic rchk(input logic [3:0] a, input logic [8:0] exp);
      host.do_read(a, v, ok);
      check({8'h00, ok}, 9'h001);
      check(v, exp);
   endtask : rchk

   // bounded wait for the interface to come up after reset or supply loss
   task automatic wait_en();
      for (int i = 0; i < 50 && bus_enabled !== 1'b1; i++) @(negedge clk);
      check({8'h00, bus_enabled}, 9'h001);
   endtask : wait_en

   task automatic settle();
      repeat (3) @(negedge clk);
   endtask : settle

   // verdict and end of run
   task automatic summarize();
      if (bad_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial begin
      rst_n           = 1'b0;
      supply_ok       = 1'b1;
      net0_write_lock = 1'b0;
      net1_write_lock = 1'b0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      wait_en();
      // defaults after power-up
      check(sw_state, 9'h1EE);
      check(w7_pos0, 9'h040);
      check(w7_pos1, 9'h000);
      rchk(ADDR_WIPER0, MID_SCALE_8B);
      rchk(ADDR_WIPER1, MID_SCALE_8B);
      rchk(ADDR_TERMINAL_CONTROL, 9'h1FF);
      rchk(ADDR_RSVD_ST, 9'h1F7);
      for (int a = 2; a < 16; a++) begin
         if (a != 4 && a != 5) rchk(4'(a), 9'h000);
      end
      // unmapped and reserved writes leave everything alone
      for (int a = 2; a < 16; a++) begin
         if (a != 4) host.do_write(4'(a), 9'h000, 1'b1);
      end
      rchk(ADDR_WIPER0, 9'h080);
      rchk(ADDR_TERMINAL_CONTROL, 9'h1FF);
      rchk(ADDR_RSVD_ST, 9'h1F7);
      // both wipers, with one idle cycle between the two writes
      host.do_write(ADDR_WIPER0, 9'h155, 1'b1);
      host.do_write(ADDR_WIPER1, 9'h0AB, 1'b1);
      rchk(ADDR_WIPER0, 9'h155);
      rchk(ADDR_WIPER1, 9'h0AB);
      check(w7_pos1, 9'h000);
      // slow host: control applies only after the command completes
      host.do_write(ADDR_TERMINAL_CONTROL, 9'h0A5, 1'b0);
      rchk(ADDR_TERMINAL_CONTROL, 9'h0A5);
      repeat (4) @(negedge clk);
      check(sw_state, 9'h1EE);
      host.finish_cmd();
      settle();
      check(sw_state, 9'h047);
      check(wiper0_pos, 9'h155);
      check(wiper1_pos, 9'h0AB);
      host.do_write(ADDR_TERMINAL_CONTROL, 9'h10E, 1'b1);
      settle();
      check(sw_state, 9'h17C);
      // locks keep the locked nibble
      net0_write_lock = 1'b1;
      host.do_write(ADDR_TERMINAL_CONTROL, 9'h0F1, 1'b1);
      settle();
      rchk(ADDR_TERMINAL_CONTROL, 9'h0FE);
      check(sw_state, 9'h0EC);
      net0_write_lock = 1'b0;
      net1_write_lock = 1'b1;
      host.do_write(ADDR_TERMINAL_CONTROL, 9'h100, 1'b1);
      settle();
      rchk(ADDR_TERMINAL_CONTROL, 9'h1F0);
      check(sw_state, 9'h1E7);
      net1_write_lock = 1'b0;
      // brown-out: bus ignored, defaults back on recovery
      supply_ok = 1'b0;
      repeat (8) @(negedge clk);
      check({8'h00, bus_enabled}, 9'h000);
      host.do_write(ADDR_WIPER0, 9'h001, 1'b1);
      host.do_read(ADDR_WIPER0, v, ok);
      check({8'h00, ok}, 9'h000);
      supply_ok = 1'b1;
      wait_en();
      rchk(ADDR_WIPER0, 9'h080);
      check(w7_pos0, 9'h040);
      rchk(ADDR_TERMINAL_CONTROL, 9'h1FF);
      // host restores its own terminal setup after the reset
      host.do_write(ADDR_TERMINAL_CONTROL, 9'h0FF, 1'b1);
      settle();
      check(sw_state, 9'h0EE);
      summarize();
   end

   // watchdog, far beyond the fewer than two hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      summarize();
   end

endmodule : digipot_volatile_register_map_bench

// ===== verif/host_ctrl_model.sv
`timescale 1ns/1ps

// -----------------------------------------------------------------
// host side of the decoded command port
// -----------------------------------------------------------------
module host_ctrl_model
   import digipot_pkg::*;
(
   // clock
   input  wire logic              clk,
   // command requests
   output logic                   cmd_valid,
   output logic                   cmd_write,
   output logic [ADDR_W-1:0]      cmd_addr,
   output logic [DATA_W-1:0]      cmd_wdata,
   output logic                   cmd_done,
   // read answers
   input  wire logic              rd_valid,
   input  wire logic [DATA_W-1:0] rd_data
);

   // idle lines carry inverted values; a read inverts the data lines again, so they can show the last written word
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr  = 4'hF;
      cmd_wdata = 9'h1FF;
      cmd_done  = 1'b0;
   end

   // one-cycle write; done may come now or later through finish_cmd
   task automatic do_write(input logic [3:0] a, input logic [8:0] d, input logic dn);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_write = 1'b1;
      cmd_addr  = a;
      cmd_wdata = d;
      cmd_done  = dn;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_done  = 1'b0;
      cmd_addr  = ~a;
      cmd_wdata = ~d;
   endtask : do_write

   // late end of a serial command, lets a slow host be modelled
   task automatic finish_cmd();
      @(negedge clk);
      cmd_done = 1'b1;
      @(negedge clk);
      cmd_done = 1'b0;
   endtask : finish_cmd

   // read; the answer pulse stands only in the cycle after the taking edge,
   // so it is taken there, before the request is dropped
   task automatic do_read(input logic [3:0] a, output logic [8:0] v, output logic ok);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_write = 1'b0;
      cmd_addr  = a;
      @(negedge clk);
      ok = rd_valid;
      v  = rd_data;
      cmd_valid = 1'b0;
      cmd_addr  = ~a;
      cmd_wdata = ~cmd_wdata;
   endtask : do_read

endmodule : host_ctrl_model
